/* File: tar_cfg.svh */
// Configuration constants for the three-address register datapath
`ifndef TAR_CFG_SVH
`define TAR_CFG_SVH

`define TAR_WORD_W        18
`define TAR_SHCNT_W       5
`define TAR_DEVSEL_W      12
`define TAR_NREG          3
`define TAR_NTOG          4
`define TAR_NCOND         6
`define TAR_REG_A         0
`define TAR_REG_B         1
`define TAR_REG_X         2
`define TAR_OP2_ONE_BIT   3
`define TAR_OP2_ZERO_BIT  4
`define TAR_WORD_RST      18'h00000
`define TAR_TOG_RST       4'h0
`define TAR_COND_RST      6'h00
`define TAR_IND_RST       4'h0
`define TAR_IND_ZERO      0
`define TAR_IND_SIGN      1
`define TAR_IND_CARRY     2
`define TAR_IND_OVFL      3

`endif

/* File: tar_pkg.sv */
// Types for the three-address register datapath
package tar_pkg;

    typedef enum logic [1:0] {
        TAR_FN_ADD,
        TAR_FN_SUB,
        TAR_FN_AND,
        TAR_FN_XOR
    } tar_fn_t;

    typedef enum logic [1:0] {
        TAR_CMD_NONE,
        TAR_CMD_REGOP,
        TAR_CMD_SHIFT,
        TAR_CMD_CTRL
    } tar_cmd_t;

    typedef enum logic [1:0] {
        TAR_SH_LEFT_LOG,
        TAR_SH_RIGHT_LOG,
        TAR_SH_LEFT_ARI,
        TAR_SH_RIGHT_ARI
    } tar_sh_t;

endpackage

/* File: tar_alu.sv */
// Three-address register operation and shift datapath
//
// Contract
// - Single and double shifts, arithmetic or logical
// - Shift count zero to thirty-one exactly
// - Whole register operation completes in one cycle
// - Function is add, subtract, AND, XOR
// - Several named sources are ORed together
// - Second operand may be constant one or zero
// - Several receivers written at once
// - Every field combination accepted without restriction
// - Zero, sign, carry, overflow indicators kept
// - Four program toggles set, reset, tested
// - One command sets or resets six conditions
// - Programmed IO leaves arithmetic registers untouched
// - Device command carries twelve-bit selection field
// - Arithmetic is binary two's complement
// - Data word eighteen bits wide
`timescale 1ns/1ps
`include "tar_cfg.svh"

module tar_alu #(
    parameter int WORD_W  = `TAR_WORD_W,
    parameter int SHCNT_W = `TAR_SHCNT_W,
    parameter int DEVSEL_W = `TAR_DEVSEL_W
) (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire tar_pkg::tar_cmd_t     cmd_kind,
    input  wire logic [2:0]            op1_sel,
    input  wire tar_pkg::tar_fn_t      op_fn,
    input  wire logic [4:0]            op2_sel,
    input  wire logic [2:0]            rcv_sel,
    input  wire tar_pkg::tar_sh_t      sh_kind,
    input  wire logic                  sh_double,
    input  wire logic [SHCNT_W-1:0]    sh_count,
    input  wire logic [3:0]            tog_set,
    input  wire logic [3:0]            tog_clr,
    input  wire logic [5:0]            cond_set,
    input  wire logic [5:0]            cond_clr,
    input  wire logic                  pio_valid,
    input  wire logic [WORD_W-1:0]     pio_wdata,
    input  wire logic [DEVSEL_W-1:0]   dev_field,
    input  wire logic                  dev_valid,
    output logic [WORD_W-1:0]          reg_a,
    output logic [WORD_W-1:0]          reg_b,
    output logic [WORD_W-1:0]          reg_x,
    output logic [WORD_W-1:0]          mdata,
    output logic [3:0]                 ind_flags,
    output logic [3:0]                 tog_flags,
    output logic [5:0]                 cond_flags,
    output logic [DEVSEL_W-1:0]        dev_sel,
    output logic                       dev_strobe
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic logic [WORD_W-1:0] or_sel(
        input logic [2:0]        sel,
        input logic [WORD_W-1:0] ra,
        input logic [WORD_W-1:0] rb,
        input logic [WORD_W-1:0] rx
    );
        or_sel = (sel[`TAR_REG_A] ? ra : '0)
               | (sel[`TAR_REG_B] ? rb : '0)
               | (sel[`TAR_REG_X] ? rx : '0);
    endfunction

    function automatic logic [2*WORD_W-1:0] shift_dw(
        input logic [2*WORD_W-1:0] v,
        input tar_pkg::tar_sh_t    k,
        input logic [SHCNT_W-1:0]  n,
        input logic                dbl
    );
        logic signed [2*WORD_W-1:0] sv;
        logic [2*WORD_W-1:0]        r;
        sv = dbl ? $signed(v) : $signed({{WORD_W{v[WORD_W-1]}}, v[WORD_W-1:0]});
        case (k)
            tar_pkg::TAR_SH_LEFT_LOG,
            tar_pkg::TAR_SH_LEFT_ARI:  r = v << n;
            tar_pkg::TAR_SH_RIGHT_LOG: r = dbl ? (v >> n)
                                       : {{WORD_W{1'b0}}, v[WORD_W-1:0] >> n};
            tar_pkg::TAR_SH_RIGHT_ARI: r = $unsigned(sv >>> n);
            default:                   r = v;
        endcase
        shift_dw = r;
    endfunction

    // ------------------------------------------------------------
    // Register operation
    // ------------------------------------------------------------
    logic [WORD_W-1:0] a_reg, a_next, b_reg, b_next, x_reg, x_next;
    logic [WORD_W-1:0] m_reg, m_next;
    logic [3:0]        ind_reg, ind_next, tog_reg, tog_next;
    logic [5:0]        cond_reg, cond_next;
    logic [DEVSEL_W-1:0] dsel_reg, dsel_next;
    logic              dstb_reg, dstb_next;

    logic [WORD_W-1:0] opnd1, opnd2, res;
    logic [WORD_W:0]   sum;
    logic [2*WORD_W-1:0] sh_res;
    logic              carry, ovfl;

    always_comb begin
        opnd1 = or_sel(op1_sel, a_reg, b_reg, x_reg);
        opnd2 = or_sel(op2_sel[2:0], a_reg, b_reg, x_reg)
              | (op2_sel[`TAR_OP2_ONE_BIT] ? WORD_W'(1) : '0);
        sum   = '0;
        carry = 1'b0;
        ovfl  = 1'b0;
        case (op_fn)
            tar_pkg::TAR_FN_ADD: begin
                sum   = {1'b0, opnd1} + {1'b0, opnd2};
                res   = sum[WORD_W-1:0];
                carry = sum[WORD_W];
                ovfl  = (opnd1[WORD_W-1] == opnd2[WORD_W-1])
                      && (res[WORD_W-1] != opnd1[WORD_W-1]);
            end
            tar_pkg::TAR_FN_SUB: begin
                sum   = {1'b0, opnd1} + {1'b0, ~opnd2} + (WORD_W+1)'(1);
                res   = sum[WORD_W-1:0];
                carry = sum[WORD_W];
                ovfl  = (opnd1[WORD_W-1] != opnd2[WORD_W-1])
                      && (res[WORD_W-1] != opnd1[WORD_W-1]);
            end
            tar_pkg::TAR_FN_AND: res = opnd1 & opnd2;
            tar_pkg::TAR_FN_XOR: res = opnd1 ^ opnd2;
            default:             res = '0;
        endcase
        sh_res = shift_dw({a_reg, b_reg}, sh_kind, sh_count, sh_double);
    end

    always_comb begin
        a_next    = a_reg;
        b_next    = b_reg;
        x_next    = x_reg;
        ind_next  = ind_reg;
        tog_next  = (tog_reg | tog_set) & ~tog_clr;
        cond_next = cond_reg;
        m_next    = m_reg;
        dsel_next = dsel_reg;
        dstb_next = 1'b0;
        case (cmd_kind)
            tar_pkg::TAR_CMD_REGOP: begin
                if (rcv_sel[`TAR_REG_A]) begin
                    a_next = res;
                end
                if (rcv_sel[`TAR_REG_B]) begin
                    b_next = res;
                end
                if (rcv_sel[`TAR_REG_X]) begin
                    x_next = res;
                end
                ind_next[`TAR_IND_ZERO]  = (res == '0);
                ind_next[`TAR_IND_SIGN]  = res[WORD_W-1];
                ind_next[`TAR_IND_CARRY] = carry;
                ind_next[`TAR_IND_OVFL]  = ovfl;
            end
            tar_pkg::TAR_CMD_SHIFT: begin
                if (sh_double) begin
                    a_next = sh_res[2*WORD_W-1:WORD_W];
                end
                b_next = sh_res[WORD_W-1:0];
                ind_next[`TAR_IND_ZERO] = (sh_res[WORD_W-1:0] == '0);
                ind_next[`TAR_IND_SIGN] = sh_res[WORD_W-1];
            end
            tar_pkg::TAR_CMD_CTRL: begin
                cond_next = (cond_reg | cond_set) & ~cond_clr;
            end
            default: begin
            end
        endcase
        if (pio_valid) begin
            m_next = pio_wdata;
        end
        if (dev_valid) begin
            dsel_next = dev_field;
            dstb_next = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            a_reg    <= `TAR_WORD_RST;
            b_reg    <= `TAR_WORD_RST;
            x_reg    <= `TAR_WORD_RST;
            m_reg    <= `TAR_WORD_RST;
            ind_reg  <= `TAR_IND_RST;
            tog_reg  <= `TAR_TOG_RST;
            cond_reg <= `TAR_COND_RST;
            dsel_reg <= '0;
            dstb_reg <= 1'b0;
        end else begin
            a_reg    <= a_next;
            b_reg    <= b_next;
            x_reg    <= x_next;
            m_reg    <= m_next;
            ind_reg  <= ind_next;
            tog_reg  <= tog_next;
            cond_reg <= cond_next;
            dsel_reg <= dsel_next;
            dstb_reg <= dstb_next;
        end
    end

    assign reg_a      = a_reg;
    assign reg_b      = b_reg;
    assign reg_x      = x_reg;
    assign mdata      = m_reg;
    assign ind_flags  = ind_reg;
    assign tog_flags  = tog_reg;
    assign cond_flags = cond_reg;
    assign dev_sel    = dsel_reg;
    assign dev_strobe = dstb_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_regop_add;
        cmd_kind == tar_pkg::TAR_CMD_REGOP && op_fn == tar_pkg::TAR_FN_ADD;
    endsequence

    property p_add_one_cycle;
        @(posedge mclk) disable iff (rst)
        (s_regop_add and rcv_sel[`TAR_REG_A]) |=> reg_a == $past(opnd1 + opnd2);
    endproperty
    a_add_one_cycle: assert property (p_add_one_cycle) else $error("add result wrong");

    property p_no_rcv;
        @(posedge mclk) disable iff (rst)
        cmd_kind == tar_pkg::TAR_CMD_REGOP && rcv_sel == 3'h0
        |=> $stable(reg_a) && $stable(reg_b) && $stable(reg_x);
    endproperty
    a_no_rcv: assert property (p_no_rcv) else $error("register written without receiver");

    property p_xor;
        @(posedge mclk) disable iff (rst)
        cmd_kind == tar_pkg::TAR_CMD_REGOP && op_fn == tar_pkg::TAR_FN_XOR && rcv_sel[`TAR_REG_X]
        |=> reg_x == ($past(opnd1) ^ $past(opnd2));
    endproperty
    a_xor: assert property (p_xor) else $error("xor result wrong");

    property p_zero_ind;
        @(posedge mclk) disable iff (rst)
        cmd_kind == tar_pkg::TAR_CMD_REGOP |=> ind_flags[`TAR_IND_ZERO] == ($past(res) == '0);
    endproperty
    a_zero_ind: assert property (p_zero_ind) else $error("zero indicator wrong");

    property p_tog;
        @(posedge mclk) disable iff (rst)
        tog_set[0] && !tog_clr[0] |=> tog_flags[0] ##1 (tog_flags[0] || $past(tog_clr[0]));
    endproperty
    a_tog: assert property (p_tog) else $error("toggle not held");

    property p_cond;
        @(posedge mclk) disable iff (rst)
        cmd_kind == tar_pkg::TAR_CMD_CTRL && cond_clr[0] |=> !cond_flags[0];
    endproperty
    a_cond: assert property (p_cond) else $error("condition not reset");

    property p_pio;
        @(posedge mclk) disable iff (rst)
        pio_valid && cmd_kind == tar_pkg::TAR_CMD_NONE
        |=> mdata == $past(pio_wdata) && $stable(reg_a) && $stable(reg_b) && $stable(reg_x);
    endproperty
    a_pio: assert property (p_pio) else $error("pio disturbed registers");

    property p_dev;
        @(posedge mclk) disable iff (rst)
        dev_valid |=> dev_strobe && dev_sel == $past(dev_field) ##1 (dev_strobe == $past(dev_valid));
    endproperty
    a_dev: assert property (p_dev) else $error("device select wrong");

    property p_dbl_shift;
        @(posedge mclk) disable iff (rst)
        cmd_kind == tar_pkg::TAR_CMD_SHIFT && sh_double && sh_kind == tar_pkg::TAR_SH_LEFT_LOG
        |=> {reg_a, reg_b} == ($past({a_reg, b_reg}) << $past(sh_count));
    endproperty
    a_dbl_shift: assert property (p_dbl_shift) else $error("double shift wrong");

    sequence s_shift_single;
        cmd_kind == tar_pkg::TAR_CMD_SHIFT && !sh_double;
    endsequence

    property p_sh_single;
        @(posedge mclk) disable iff (rst)
        s_shift_single |=> $stable(reg_a) && $stable(reg_x);
    endproperty
    a_sh_single: assert property (p_sh_single) else $error("a or x shifted");

    property p_sh_ari;
        @(posedge mclk) disable iff (rst)
        (s_shift_single and (sh_kind == tar_pkg::TAR_SH_RIGHT_ARI))
        |=> $signed(reg_b) == ($signed($past(b_reg)) >>> $past(sh_count));
    endproperty
    a_sh_ari: assert property (p_sh_ari) else $error("arith shift wrong");

endmodule

/* File: three_address_register_alu_test.sv */
// Self-checking testbench for the three-address register datapath
`timescale 1ns/1ps
`include "tar_cfg.svh"

module three_address_register_alu_test;

    typedef struct {
        logic [17:0] a, b, x, md;
        logic [3:0]  ind, tog;
        logic [5:0]  cond;
        logic [11:0] dev;
        logic        stb;
    } tar_exp_t;

    logic                 mclk = 1'b0;
    logic                 rst  = 1'b1;
    tar_pkg::tar_cmd_t    cmd_kind;
    tar_pkg::tar_fn_t     op_fn;
    tar_pkg::tar_sh_t     sh_kind;
    logic [2:0]           op1_sel, rcv_sel;
    logic [4:0]           op2_sel, sh_count;
    logic [3:0]           tog_set, tog_clr;
    logic [5:0]           cond_set, cond_clr;
    logic                 sh_double, pio_valid, dev_valid;
    logic [17:0]          pio_wdata, reg_a, reg_b, reg_x, mdata;
    logic [11:0]          dev_field, dev_sel;
    logic [3:0]           ind_flags, tog_flags;
    logic [5:0]           cond_flags;
    logic                 dev_strobe;
    tar_exp_t             m, e;
    tar_exp_t             exq[$];
    int                   failures = 0;
    int                   samples_checked = 0;
    int                   cycles = 0;
    int                   i;
    logic [4:0]           cnts[4] = '{5'h00, 5'h01, 5'h11, 5'h1f};

    tar_alu dut (.mclk(mclk), .rst(rst), .cmd_kind(cmd_kind), .op1_sel(op1_sel),
        .op_fn(op_fn), .op2_sel(op2_sel), .rcv_sel(rcv_sel), .sh_kind(sh_kind),
        .sh_double(sh_double), .sh_count(sh_count), .tog_set(tog_set), .tog_clr(tog_clr),
        .cond_set(cond_set), .cond_clr(cond_clr), .pio_valid(pio_valid),
        .pio_wdata(pio_wdata), .dev_field(dev_field), .dev_valid(dev_valid),
        .reg_a(reg_a), .reg_b(reg_b), .reg_x(reg_x), .mdata(mdata), .ind_flags(ind_flags),
        .tog_flags(tog_flags), .cond_flags(cond_flags), .dev_sel(dev_sel),
        .dev_strobe(dev_strobe));

    initial begin
        forever #2.5 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Reference model: next state from the inputs now standing
    // ------------------------------------------------------------
    task automatic step();
        logic [17:0] p, q, r;
        logic [18:0] s;
        logic [35:0] w;
        if (rst) begin
            m = '{default: '0};
        end else begin
            m.tog = (m.tog | tog_set) & ~tog_clr;
            if (pio_valid) m.md = pio_wdata;
            if (dev_valid) m.dev = dev_field;
            m.stb = dev_valid;
            if (cmd_kind == tar_pkg::TAR_CMD_CTRL) m.cond = (m.cond | cond_set) & ~cond_clr;
            if (cmd_kind == tar_pkg::TAR_CMD_REGOP) begin
                p = ({18{op1_sel[0]}} & m.a) | ({18{op1_sel[1]}} & m.b)
                    | ({18{op1_sel[2]}} & m.x);
                q = ({18{op2_sel[0]}} & m.a) | ({18{op2_sel[1]}} & m.b)
                    | ({18{op2_sel[2]}} & m.x) | {17'h00000, op2_sel[3]};
                case (op_fn)
                    tar_pkg::TAR_FN_ADD: s = {1'b0, p} + {1'b0, q};
                    tar_pkg::TAR_FN_SUB: s = {1'b0, p} + {1'b0, ~q} + 19'h00001;
                    tar_pkg::TAR_FN_AND: s = {1'b0, p & q};
                    default:             s = {1'b0, p ^ q};
                endcase
                r = s[17:0];
                m.ind[3] = (op_fn == tar_pkg::TAR_FN_ADD) ? (p[17] == q[17]) && (r[17] != p[17])
                         : (op_fn == tar_pkg::TAR_FN_SUB) && (p[17] != q[17]) && (r[17] != p[17]);
                m.ind[2] = !op_fn[1] && s[18];
                m.ind[1:0] = {r[17], r == 18'h00000};
                if (rcv_sel[0]) m.a = r;
                if (rcv_sel[1]) m.b = r;
                if (rcv_sel[2]) m.x = r;
            end
            if (cmd_kind == tar_pkg::TAR_CMD_SHIFT) begin
                w = sh_double ? {m.a, m.b} : {{18{m.b[17]}}, m.b};
                if (!sh_kind[0]) w = w << sh_count;
                else if (sh_kind == tar_pkg::TAR_SH_RIGHT_ARI) w = $signed(w) >>> sh_count;
                else w = (sh_double ? w : {18'h00000, w[17:0]}) >> sh_count;
                if (sh_double) {m.a, m.b} = w;
                else m.b = w[17:0];
                m.ind[1:0] = {w[17], w[17:0] == 18'h00000};
            end
        end
        exq.push_back(m);
    endtask

    task automatic go();
        step();
        @(negedge mclk);
    endtask

    task automatic three_operand_reg_cmd(input logic [2:0] o1, input int f, input logic [4:0] o2,
                       input logic [2:0] rv);
        cmd_kind = tar_pkg::TAR_CMD_REGOP;
        op1_sel = o1;
        op_fn = tar_pkg::tar_fn_t'(f);
        op2_sel = o2;
        rcv_sel = rv;
        go();
    endtask

    task automatic rnd();
        cmd_kind = tar_pkg::tar_cmd_t'($urandom_range(3));
        op_fn = tar_pkg::tar_fn_t'($urandom_range(3));
        sh_kind = tar_pkg::tar_sh_t'($urandom_range(3));
        {op1_sel, rcv_sel, op2_sel, sh_count, sh_double} = 17'($urandom);
        {tog_set, tog_clr, cond_set, cond_clr} = 20'($urandom & $urandom);
        {pio_valid, dev_valid, pio_wdata, dev_field} = 32'($urandom);
    endtask

    task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Monitor: compare each registered result with the oldest note
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        cycles++;
        if (cycles >= 4000) begin
            failures++;
            end_sim();
        end else begin
            #1;
            if (exq.size() > 0) begin
                e = exq.pop_front();
                check("reg_a", reg_a, e.a);
                check("reg_b", reg_b, e.b);
                check("reg_x", reg_x, e.x);
                check("mdata", mdata, e.md);
                check("ind_flags", ind_flags, e.ind);
                check("tog_flags", tog_flags, e.tog);
                check("cond_flags", cond_flags, e.cond);
                check("dev_sel", dev_sel, e.dev);
                check("dev_strobe", dev_strobe, e.stb);
            end
        end
    end

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h670f44bd));
        {op1_sel, rcv_sel, op2_sel, sh_count, sh_double} = 17'h00000;
        {tog_set, tog_clr, cond_set, cond_clr} = 20'h00000;
        {pio_valid, dev_valid, pio_wdata, dev_field} = 32'h00000000;
        cmd_kind = tar_pkg::TAR_CMD_NONE;
        op_fn = tar_pkg::TAR_FN_ADD;
        sh_kind = tar_pkg::TAR_SH_LEFT_LOG;
        m = '{default: '0};
        go();
        go();
        rst = 1'b0;
        three_operand_reg_cmd(3'h0, 1, 5'h08, 3'h1);
        three_operand_reg_cmd(3'h1, 0, 5'h10, 3'h6);
        three_operand_reg_cmd(3'h3, 0, 5'h08, 3'h1);
        three_operand_reg_cmd(3'h4, 3, 5'h01, 3'h0);
        $display("test directed done");
        for (i = 0; i < 64; i++) begin
            three_operand_reg_cmd(3'($urandom), i % 4, 5'($urandom), 3'($urandom));
            cmd_kind = tar_pkg::TAR_CMD_SHIFT;
            sh_kind = tar_pkg::tar_sh_t'(i % 4);
            sh_double = i[2];
            sh_count = cnts[i[4:3]];
            go();
        end
        $display("test functions and shifts done");
        repeat (1500) begin
            rnd();
            go();
        end
        $display("test random done");
        rst = 1'b1;
        rnd();
        go();
        go();
        rst = 1'b0;
        repeat (200) begin
            rnd();
            go();
        end
        $display("test reset mid-run done");
        end_sim();
    end

endmodule
